//--- testbench.sv
// self-checking testbench for the eprom host controller
`timescale 1ns/1ps
module testbench;
	import uvep_pkg::*;
	localparam int PW = 20;
	logic clk, rst_n, req_valid, req_ready, rsp_valid;
	uvep_req_s req;
	uvep_pins_s pins;
	logic [DATA_W-1:0] rsp_data, dev_data, bus;
	int n_fail = 0;
	int cmp_count = 0;
	assign bus = pins.data_oe ? pins.data_o : dev_data;
	uvep_host #(.PULSE_CYCLES(PW)) uvep_host_i(.clk(clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .pins(pins), .data_i(bus));
	uvep_dev_model uvep_dev_model_i(.pins(pins), .data_i(dev_data));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic print_verdict();
		if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one request; counts cycles with select low under the supply
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int i;
		int lo;
		i = 0;
		lo = 0;
		while (req_ready !== 1'b1 && i < 40) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (i == 40) begin
			n_fail++;
			print_verdict();
		end
		req = '{a, d, wr};
		req_valid = 1'b1;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		check(req_ready, 1'b0);
		for (i = 0; i < 600 && rsp_valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
			if (pins.chip_sel_n === 1'b0 && pins.vpp_on === 1'b1) lo++;
			if (pins.chip_sel_n === 1'b0) check(pins.data_oe, wr);
		end
		if (i == 600) begin
			n_fail++;
			print_verdict();
		end
		check(lo, wr ? PW : 0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		check(rsp_data, exp);
	endtask
	task automatic t_erased();
		rd(12'h000, 8'hff);
		rd(12'hfff, 8'hff);
	endtask
	task automatic t_program_verify();
		xfer(1'b1, 12'h5a3, 8'h3c);
		rd(12'h5a3, 8'h3c);
		rd(12'h5a2, 8'hff);
	endtask
	task automatic t_clear_only();
		xfer(1'b1, 12'h5a3, 8'hf0);
		rd(12'h5a3, 8'h30);
	endtask
	task automatic t_any_order();
		xfer(1'b1, 12'h801, 8'h81);
		xfer(1'b1, 12'h001, 8'h01);
		rd(12'h801, 8'h81);
		rd(12'h001, 8'h01);
	endtask
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check({pins.chip_sel_n, pins.oe_n, pins.vpp_on, pins.data_oe}, 4'hc);
		t_erased();
		t_program_verify();
		t_clear_only();
		t_any_order();
		print_verdict();
	end
endmodule

//--- uvep_dev_model.sv
// behavioural eprom model facing the host controller
`timescale 1ns/1ps
module uvep_dev_model
	import uvep_pkg::*;
(
	input wire uvep_pins_s pins,
	output logic [DATA_W-1:0] data_i
);
	logic [DATA_W-1:0] mem [0:4095];
	logic [DATA_W-1:0] last = 8'hff;
	logic sel, sel_late;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// data shows only after the access time, so an early sample sees the stale inverse
	assign sel = !pins.chip_sel_n && !pins.oe_n && !pins.vpp_on;
	assign #(ACCESS_NS) sel_late = sel;
	// the byte lands at the end of the select pulse, bits only ever cleared
	always @(posedge pins.chip_sel_n) begin
		if (pins.vpp_on) mem[pins.addr] &= pins.data_o;
	end
	// released pins show a changed value so a stale byte cannot pass
	always @* begin
		if (sel && sel_late) begin
			data_i = mem[pins.addr];
			last = data_i;
		end else begin
			data_i = ~last;
		end
	end
endmodule

//--- uvep_host.sv
// controller that reads and programs the uv eprom through its pins
`timescale 1ns/1ps
// Overview of operation
// - programming supply applied to request programming
// - address and data driven during programming
// - one low pulse after address, data stable
// - pulse width within 45 to 55 ms
// - chip select never held low steadily
// - one pulse per location, any order
// - supply switched only while select high
module uvep_host
	import uvep_pkg::*;
#(
	parameter int PULSE_CYCLES = PULSE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire uvep_req_s req,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	output uvep_pins_s pins,
	input wire logic [DATA_W-1:0] data_i
);
	uvep_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	uvep_pins_s pins_q, pins_d;
	logic [DATA_W-1:0] rsp_data_q, rsp_data_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [DATA_W-1:0] din_s1_q, din_s2_q;

	// data pins are asynchronous to clk; only the second stage feeds logic
	always_ff @(posedge clk) begin
		din_s1_q <= data_i;
		din_s2_q <= din_s1_q;
	end

	assign req_ready = (state_q == UVEP_IDLE);
	assign pins = pins_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		pins_d = pins_q;
		rsp_data_d = rsp_data_q;
		rsp_valid_d = 1'b0;
		case (state_q)
			UVEP_IDLE: begin
				pins_d.chip_sel_n = 1'b1;
				pins_d.oe_n = 1'b1;
				pins_d.data_oe = 1'b0;
				cnt_d = '0;
				if (req_valid) begin
					pins_d.addr = req.addr;
					if (req.write) begin
						// supply changes only with select high
						pins_d.vpp_on = 1'b1;
						pins_d.data_o = req.data;
						pins_d.data_oe = 1'b1;
						state_d = UVEP_PG_SET;
					end else begin
						pins_d.vpp_on = 1'b0;
						pins_d.chip_sel_n = 1'b0;
						pins_d.oe_n = 1'b0;
						state_d = UVEP_RD_ACC;
					end
				end
			end
			UVEP_RD_ACC: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(ACCESS_CYC + 2)) begin
					// two extra cycles cover the input synchroniser
					rsp_data_d = din_s2_q;
					rsp_valid_d = 1'b1;
					pins_d.chip_sel_n = 1'b1;
					pins_d.oe_n = 1'b1;
					cnt_d = '0;
					state_d = UVEP_RD_FLT;
				end
			end
			UVEP_RD_FLT: begin
				// let the device bus float before another party may drive
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(FLOAT_CYC)) begin
					state_d = UVEP_IDLE;
				end
			end
			UVEP_PG_SET: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(SETUP_CYC)) begin
					pins_d.chip_sel_n = 1'b0;
					cnt_d = '0;
					state_d = UVEP_PG_PLS;
				end
			end
			UVEP_PG_PLS: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(PULSE_CYCLES - 1)) begin
					pins_d.chip_sel_n = 1'b1;
					cnt_d = '0;
					state_d = UVEP_PG_HLD;
				end
			end
			UVEP_PG_HLD: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(SETUP_CYC)) begin
					pins_d.data_oe = 1'b0;
					pins_d.vpp_on = 1'b0;
					rsp_valid_d = 1'b1;
					state_d = UVEP_IDLE;
				end
			end
			default: begin
				state_d = UVEP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= UVEP_IDLE;
			cnt_q <= '0;
			pins_q <= '{addr: '0, chip_sel_n: 1'b1, oe_n: 1'b1, vpp_on: 1'b0,
				data_o: '0, data_oe: 1'b0};
			rsp_data_q <= '0;
			rsp_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pins_q <= pins_d;
			rsp_data_q <= rsp_data_d;
			rsp_valid_q <= rsp_valid_d;
		end
	end

	// checker helper: cycles spent with select low under the supply
	logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
	always_comb begin
		low_cnt_d = low_cnt_q + 1'b1;
		if (pins_q.chip_sel_n || !pins_q.vpp_on) begin
			low_cnt_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_cnt_q <= '0;
		end else begin
			low_cnt_q <= low_cnt_d;
		end
	end

	AST_PULSE_MAX: assert property (@(posedge clk) disable iff (!rst_n)
		low_cnt_q <= CNT_W'(PULSE_MAX_CYC))
		else $error("programming pulse too long");
	AST_VPP_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(pins_q.vpp_on) |-> pins_q.chip_sel_n && $past(pins_q.chip_sel_n))
		else $error("supply switched with select low");
	AST_PULSE_DATA: assert property (@(posedge clk) disable iff (!rst_n)
		(!pins_q.chip_sel_n && pins_q.vpp_on) |-> pins_q.data_oe && pins_q.oe_n)
		else $error("data not driven during pulse");
	AST_SETUP: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(pins_q.chip_sel_n) && pins_q.vpp_on |-> $past(pins_q.data_oe, 8))
		else $error("pulse started before data setup");
	AST_NO_CONTEND: assert property (@(posedge clk) disable iff (!rst_n)
		!pins_q.oe_n |-> !pins_q.data_oe && !pins_q.vpp_on)
		else $error("bus contention on read");
	AST_RD_DONE: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(pins_q.oe_n) |-> ##[1:70] rsp_valid)
		else $error("read did not complete");
	AST_ONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pins_q.chip_sel_n) && pins_q.vpp_on |-> ##1 pins_q.chip_sel_n [*8])
		else $error("second pulse too soon");
	AST_IDLE_READY: assert property (@(posedge clk) disable iff (!rst_n)
		req_ready |-> pins_q.chip_sel_n)
		else $error("select held low while idle");

	// a pulse that ends must have lasted exactly the configured width
	AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pins_q.chip_sel_n) && pins_q.vpp_on |-> low_cnt_q == CNT_W'(PULSE_CYCLES))
		else $error("programming pulse width wrong");

	// the cell latches whatever stands on the pins, so nothing may move mid-pulse
	AST_PULSE_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		!pins_q.chip_sel_n && pins_q.vpp_on |-> $stable(pins_q.addr) && $stable(pins_q.data_o))
		else $error("address or data moved during pulse");

	// data must outlive the pulse by the hold time
	AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(pins_q.data_oe) |-> pins_q.chip_sel_n && $past(pins_q.chip_sel_n, 8))
		else $error("data released too close to pulse");

	// supply comes up only with the device deselected and our data on the pins
	AST_SUPPLY_ON: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pins_q.vpp_on) |-> pins_q.chip_sel_n && pins_q.oe_n && pins_q.data_oe)
		else $error("supply raised in wrong pin state");

	// after its single pulse a write ends with the supply off
	AST_WR_DONE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pins_q.chip_sel_n) && pins_q.vpp_on |-> ##[1:300] (!pins_q.vpp_on && rsp_valid))
		else $error("write did not finish after its pulse");

	// another bus party may drive only after the float delay
	AST_FLOAT_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pins_q.oe_n) && !pins_q.vpp_on |-> !req_ready [*8])
		else $error("ready before outputs floated");

	AST_RD_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
		!pins_q.oe_n && !$past(pins_q.oe_n) |-> $stable(pins_q.addr))
		else $error("address moved during read");
endmodule

//--- uvep_pkg.sv
// package for the uv eprom programmer/reader controller
package uvep_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 8;
	// programming pulse: nominal 50 ms, limits 45..55 ms
	localparam longint PULSE_NOM_NS = 64'd50000000;
	localparam longint PULSE_MAX_NS = 64'd55000000;
	localparam int PULSE_CYC = int'(PULSE_NOM_NS / CLK_PERIOD_NS);
	localparam int PULSE_MAX_CYC = int'(PULSE_MAX_NS / CLK_PERIOD_NS);
	// setup and hold around the pulse, 2 us each
	localparam int SETUP_NS = 2000;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// read access: address access time and output float delay
	localparam int ACCESS_NS = 450;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_NS = 100;
	localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;
	typedef enum logic [2:0] {
		UVEP_IDLE = 3'b000,
		UVEP_RD_ACC = 3'b001,
		UVEP_RD_FLT = 3'b010,
		UVEP_PG_SET = 3'b011,
		UVEP_PG_PLS = 3'b100,
		UVEP_PG_HLD = 3'b101
	} uvep_state_e;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic write;
	} uvep_req_s;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic chip_sel_n;
		logic oe_n;
		logic vpp_on;
		logic [DATA_W-1:0] data_o;
		logic data_oe;
	} uvep_pins_s;
endpackage
